/* File: core/addr_map_decoder.sv */
// address decoder: steers one master access to internal sram, the bit alias,
// external memory or the forwarding port tagged with its processor bus
// assumes one master, a forwarding fabric that answers, resp taken when shown
// Notes on behaviour
// RULE1 - code buses carry only addresses below the sram region base
// RULE2 - system bus serves sram through external peripherals, and above private area
// RULE3 - instruction fetches into the sram region are accepted on the system bus
// RULE4 - 1 MB from sram base is bit addressable through a 32 MB alias; only the backed sram block words are here, the rest of the alias faults
// RULE5 - alias write sets one sram bit from data bit 0; read returns 0 or 1
// RULE6 - unaligned word and half-word accesses work, taking extra cycles
// RULE7 - 32 KB sram block sits at the top of the code region
// RULE8 - second 32 KB sram block starts at the sram region base
// RULE9 - 256-byte external interface control window is routed to that interface
// RULE10 - external memory lies in external ram space, at most 24 address bits
// RULE11 - external data path is 8 or 16 bits and memory must match
// RULE12 - each external memory access takes exactly four bus clocks
// RULE13 - sync or async external memory, only one type configured at once
// RULE14 - fetches from external memory allowed only when it is 16 bits wide
// RULE15 - external memory gets no read or execute protection
// RULE16 - system control and debug registers go on the private peripheral bus
// RULE17 - external ram region then external peripheral region at their bases
// RULE18 - low 24 system address bits pass unchanged to the external address
`timescale 1ns/10ps
module addr_map_decoder #(
	parameter int SRAM_WORDS = amap_pkg::SRAM_BLK_BYTES / 4
) (
	input logic sys_clk,
	input logic rst,
	input logic req_valid,
	output logic req_ready,
	input logic [31:0] req_addr,
	input amap_pkg::acc_size_t req_size,
	input logic req_write,
	input logic req_fetch,
	input logic [31:0] req_wdata,
	output logic resp_valid,
	output logic [31:0] resp_rdata,
	output logic resp_err,
	output logic fwd_valid,
	input logic fwd_ready,
	output amap_pkg::bus_t fwd_bus,
	output logic fwd_ext_regs,
	output logic [31:0] fwd_addr,
	output amap_pkg::acc_size_t fwd_size,
	output logic fwd_write,
	output logic [31:0] fwd_wdata,
	input logic [31:0] fwd_rdata,
	input logic fwd_err,
	input logic ext_width16,
	input logic ext_sync,
	output logic [amap_pkg::EXT_ADDR_BITS-1:0] ext_addr,
	output logic [15:0] ext_dq_out,
	input logic [15:0] ext_dq_in,
	output logic ext_dq_oe_n,
	output logic ext_cs_n,
	output logic ext_oe_n,
	output logic ext_we_n,
	output logic [1:0] ext_be_n,
	output logic ext_adv_n,
	output logic ext_sclk
);
	localparam int AW = $clog2(SRAM_WORDS);

	if (SRAM_WORDS * 4 > amap_pkg::SRAM_BLK_BYTES || (1 << AW) != SRAM_WORDS) begin : g_chk
		$error("sram words must be a power of two within the block");
	end

	typedef enum logic [3:0] {
		ST_IDLE, ST_FWD, ST_MEM, ST_MEM_CAP, ST_BB_RD, ST_BB_CAP, ST_EXT, ST_RESP
	} state_t;

	state_t st_q, st_d;
	logic [31:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
	amap_pkg::acc_size_t size_q, size_d;
	amap_pkg::target_t tgt_q, tgt_d, dec_tgt;
	amap_pkg::bus_t bus_q, bus_d, dec_bus;
	logic write_q, write_d, err_q, err_d, wide_q, wide_d, sync_q, sync_d;
	logic xregs_q, xregs_d, dec_xregs;
	logic [2:0] idx_q, idx_d;
	logic [31:0] req_bb_off, bb_off, cur, unit_wdata, rword, cmask, merged, bb_word_new;
	logic [1:0] umask, lane;
	logic [2:0] nbytes, rem, room, cnt;
	logic [7:0] be8;
	logic [3:0] unit_be, mem_be;
	logic [4:0] bb_bit;
	logic last, code_en, sys_en, mem_we;
	logic [AW-1:0] mem_addr;
	logic [31:0] mem_wdata, code_rdata, sys_rdata;
	ext_unit_if eu();

	always_comb begin
		req_bb_off = req_addr - amap_pkg::BB_ALIAS_BASE;
		if (req_addr < amap_pkg::SRAM_BASE) begin
			dec_bus = amap_pkg::BUS_CODE; // see RULE1
		end else if (req_addr >= amap_pkg::PRIV_BASE && req_addr <= amap_pkg::PRIV_TOP) begin
			dec_bus = amap_pkg::BUS_PRIV; // see RULE16
		end else begin
			// sram fetches land here too, served in the same cycles as the code path // see RULE2 RULE3
			dec_bus = amap_pkg::BUS_SYS;
		end
		dec_xregs = req_addr >= amap_pkg::EXT_REGS_BASE
			&& req_addr <= amap_pkg::EXT_REGS_TOP; // see RULE9
		dec_tgt = amap_pkg::TGT_FWD;
		if (req_addr >= amap_pkg::CODE_SRAM_BASE && req_addr < amap_pkg::SRAM_BASE) begin
			dec_tgt = amap_pkg::TGT_SRAM_CODE; // see RULE7
		end else if (req_addr >= amap_pkg::SRAM_BASE && req_addr <= amap_pkg::SRAM_BLK_TOP) begin
			dec_tgt = amap_pkg::TGT_SRAM_SYS; // see RULE8
		end else if (req_addr >= amap_pkg::BB_ALIAS_BASE
			&& req_addr <= amap_pkg::BB_ALIAS_TOP) begin
			// only the backed part of the 1 MB bit region answers // see RULE4
			dec_tgt = req_bb_off[24:7] < 18'(SRAM_WORDS) ? amap_pkg::TGT_BITBAND
				: amap_pkg::TGT_FAULT;
		end else if (req_addr >= amap_pkg::EXT_RAM_BASE && req_addr <= amap_pkg::EXT_WIN_TOP) begin
			// see RULE10 RULE17; narrow memory cannot feed fetches // see RULE14
			dec_tgt = (!req_fetch || ext_width16) ? amap_pkg::TGT_EXT : amap_pkg::TGT_FAULT;
		end else if (req_addr >= amap_pkg::EXT_RAM_BASE && req_addr < amap_pkg::EXT_PERIPH_BASE) begin
			dec_tgt = amap_pkg::TGT_FAULT; // beyond 24 address bits // see RULE10
		end
	end

	// one unit is the part of the access that fits one memory word // see RULE6
	always_comb begin
		cur = addr_q + 32'(idx_q);
		if (tgt_q == amap_pkg::TGT_EXT) begin
			umask = wide_q ? 2'b01 : 2'b00; // see RULE11
		end else begin
			umask = 2'b11;
		end
		lane = cur[1:0] & umask;
		unique case (size_q)
			amap_pkg::SZ_BYTE: nbytes = 3'd1;
			amap_pkg::SZ_HALF: nbytes = 3'd2;
			default: nbytes = 3'd4;
		endcase
		rem = nbytes - idx_q;
		room = {1'b0, umask} + 3'd1 - {1'b0, lane};
		cnt = rem < room ? rem : room;
		last = (idx_q + cnt) >= nbytes;
		be8 = 8'((8'd1 << cnt) - 8'd1) << lane;
		unit_be = be8[3:0];
		unit_wdata = (wdata_q >> {idx_q, 3'b000}) << {lane, 3'b000};
		if (tgt_q == amap_pkg::TGT_EXT) begin
			rword = {16'h0000, eu.rdata};
		end else begin
			rword = tgt_q == amap_pkg::TGT_SRAM_CODE ? code_rdata : sys_rdata;
		end
		cmask = 32'((33'd1 << {cnt, 3'b000}) - 33'd1);
		merged = rdata_q | (((rword >> {lane, 3'b000}) & cmask) << {idx_q, 3'b000});
		bb_off = addr_q - amap_pkg::BB_ALIAS_BASE;
		bb_bit = bb_off[6:2];
		bb_word_new = sys_rdata;
		bb_word_new[bb_bit] = wdata_q[amap_pkg::BB_DATA_BIT]; // see RULE5
	end

	always_comb begin
		code_en = 1'b0;
		sys_en = 1'b0;
		mem_we = write_q;
		mem_be = unit_be;
		mem_addr = cur[AW+1:2];
		mem_wdata = unit_wdata;
		if (st_q == ST_MEM) begin
			code_en = tgt_q == amap_pkg::TGT_SRAM_CODE;
			sys_en = tgt_q == amap_pkg::TGT_SRAM_SYS;
		end else if (st_q == ST_BB_RD || st_q == ST_BB_CAP) begin
			// read, then on writes only write back the same word with nothing between // see RULE4 RULE5
			sys_en = st_q == ST_BB_RD || write_q;
			mem_we = st_q == ST_BB_CAP;
			mem_be = 4'hf;
			mem_addr = bb_off[AW+6:7];
			mem_wdata = bb_word_new;
		end
	end

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		size_d = size_q;
		tgt_d = tgt_q;
		bus_d = bus_q;
		write_d = write_q;
		err_d = err_q;
		wide_d = wide_q;
		sync_d = sync_q;
		xregs_d = xregs_q;
		idx_d = idx_q;
		unique case (st_q)
			ST_IDLE: begin
				if (req_valid) begin
					addr_d = req_addr;
					wdata_d = req_wdata;
					size_d = req_size;
					write_d = req_write;
					tgt_d = dec_tgt;
					bus_d = dec_bus;
					xregs_d = dec_xregs;
					// memory setup is caught per access, one type at a time // see RULE13
					wide_d = ext_width16;
					sync_d = ext_sync;
					idx_d = 3'd0;
					rdata_d = 32'h0000_0000;
					err_d = 1'b0;
					unique case (dec_tgt)
						amap_pkg::TGT_FWD: st_d = ST_FWD;
						amap_pkg::TGT_SRAM_CODE, amap_pkg::TGT_SRAM_SYS: st_d = ST_MEM;
						amap_pkg::TGT_BITBAND: st_d = ST_BB_RD;
						amap_pkg::TGT_EXT: st_d = ST_EXT;
						default: begin
							err_d = 1'b1;
							st_d = ST_RESP;
						end
					endcase
				end
			end
			ST_FWD: begin
				if (fwd_ready) begin
					rdata_d = fwd_rdata;
					err_d = fwd_err;
					st_d = ST_RESP;
				end
			end
			ST_MEM: begin
				if (write_q) begin
					idx_d = idx_q + cnt;
					st_d = last ? ST_RESP : ST_MEM;
				end else begin
					st_d = ST_MEM_CAP;
				end
			end
			ST_MEM_CAP: begin
				rdata_d = merged;
				idx_d = idx_q + cnt;
				st_d = last ? ST_RESP : ST_MEM;
			end
			ST_BB_RD: st_d = ST_BB_CAP;
			ST_BB_CAP: begin
				if (!write_q) begin
					rdata_d = {31'h0000_0000, sys_rdata[bb_bit]}; // see RULE5
				end
				st_d = ST_RESP;
			end
			ST_EXT: begin
				if (eu.done) begin
					if (!write_q) begin
						rdata_d = merged;
					end
					idx_d = idx_q + cnt;
					st_d = last ? ST_RESP : ST_EXT;
				end
			end
			ST_RESP: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			addr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			size_q <= amap_pkg::SZ_BYTE;
			tgt_q <= amap_pkg::TGT_FWD;
			bus_q <= amap_pkg::BUS_CODE;
			write_q <= 1'b0;
			err_q <= 1'b0;
			wide_q <= 1'b0;
			sync_q <= 1'b0;
			xregs_q <= 1'b0;
			idx_q <= 3'd0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			size_q <= size_d;
			tgt_q <= tgt_d;
			bus_q <= bus_d;
			write_q <= write_d;
			err_q <= err_d;
			wide_q <= wide_d;
			sync_q <= sync_d;
			xregs_q <= xregs_d;
			idx_q <= idx_d;
		end
	end

	assign req_ready = st_q == ST_IDLE;
	assign resp_valid = st_q == ST_RESP;
	assign resp_rdata = rdata_q;
	assign resp_err = err_q;
	assign fwd_valid = st_q == ST_FWD;
	assign fwd_bus = bus_q;
	assign fwd_ext_regs = xregs_q;
	assign fwd_addr = addr_q;
	assign fwd_size = size_q;
	assign fwd_write = write_q;
	assign fwd_wdata = wdata_q;
	assign eu.valid = st_q == ST_EXT;
	assign eu.addr = cur[amap_pkg::EXT_ADDR_BITS-1:0]; // see RULE18
	assign eu.write = write_q;
	assign eu.be = unit_be[1:0];
	assign eu.wdata = unit_wdata[15:0];
	assign eu.wide = wide_q;
	assign eu.sync = sync_q;

	sram_bank #(.WORDS(SRAM_WORDS)) u_code_sram (
		.sys_clk(sys_clk), .en(code_en), .we(mem_we), .be(mem_be),
		.addr(mem_addr), .wdata(mem_wdata), .rdata(code_rdata)
	);
	sram_bank #(.WORDS(SRAM_WORDS)) u_sys_sram (
		.sys_clk(sys_clk), .en(sys_en), .we(mem_we), .be(mem_be),
		.addr(mem_addr), .wdata(mem_wdata), .rdata(sys_rdata)
	);
	ext_mem_if u_ext (
		.sys_clk(sys_clk), .rst(rst), .unit(eu.target), .ext_addr(ext_addr),
		.ext_dq_out(ext_dq_out), .ext_dq_in(ext_dq_in), .ext_dq_oe_n(ext_dq_oe_n),
		.ext_cs_n(ext_cs_n), .ext_oe_n(ext_oe_n), .ext_we_n(ext_we_n),
		.ext_be_n(ext_be_n), .ext_adv_n(ext_adv_n), .ext_sclk(ext_sclk)
	);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_code_bus_range: assert property (fwd_valid && fwd_bus == amap_pkg::BUS_CODE // see RULE1
		|-> fwd_addr < amap_pkg::SRAM_BASE) else $error("code bus outside code region");
	a_sys_bus_range: assert property (fwd_valid && fwd_bus == amap_pkg::BUS_SYS |-> // see RULE2
		(fwd_addr >= amap_pkg::SRAM_BASE && fwd_addr <= amap_pkg::EXT_PERIPH_TOP)
		|| fwd_addr >= amap_pkg::SYS_HI_BASE) else $error("system bus outside its ranges");
	a_priv_range: assert property (fwd_valid && fwd_bus == amap_pkg::BUS_PRIV |-> // see RULE16
		fwd_addr >= amap_pkg::PRIV_BASE && fwd_addr <= amap_pkg::PRIV_TOP)
		else $error("private bus outside its range");
	a_sram_fetch_ok: assert property (req_valid && req_ready && req_fetch // see RULE3
		&& req_addr >= amap_pkg::SRAM_BASE && req_addr <= amap_pkg::SRAM_BLK_TOP - 32'd3
		|-> ##[2:7] resp_valid && !resp_err) else $error("sram fetch not served");
	a_bitband_map: assert property (req_valid && req_ready // see RULE4
		&& dec_tgt == amap_pkg::TGT_BITBAND |=> st_q == ST_BB_RD && sys_en
		&& mem_addr == $past(req_addr[AW+6:7])) else $error("alias word maps wrongly");
	a_bitband_read: assert property (resp_valid && tgt_q == amap_pkg::TGT_BITBAND // see RULE5
		&& !write_q |-> resp_rdata[31:1] == 31'h0000_0000) else $error("alias read not 0 or 1");
	a_bitband_write: assert property (st_q == ST_BB_RD && write_q |=> sys_en && mem_we // see RULE5
		&& mem_wdata[bb_bit] == wdata_q[0] ##1 resp_valid) else $error("alias write lost");
	a_unaligned_ok: assert property (req_valid && req_ready && req_size == amap_pkg::SZ_WORD // see RULE6
		&& dec_tgt == amap_pkg::TGT_SRAM_SYS && req_addr[1:0] != 2'b00
		&& req_addr <= amap_pkg::SRAM_BLK_TOP - 32'd3
		|-> ##[3:8] resp_valid && !resp_err) else $error("unaligned word not served");
	a_code_sram: assert property (req_valid && req_ready && req_addr >= amap_pkg::CODE_SRAM_BASE // see RULE7
		&& req_addr < amap_pkg::SRAM_BASE |=> st_q == ST_MEM && code_en)
		else $error("code sram block missed");
	a_ext_regs: assert property (fwd_valid && fwd_ext_regs |-> fwd_bus == amap_pkg::BUS_SYS // see RULE9
		&& fwd_addr >= amap_pkg::EXT_REGS_BASE && fwd_addr <= amap_pkg::EXT_REGS_TOP)
		else $error("control window misrouted");
	a_ext_window: assert property (eu.valid |-> addr_q >= amap_pkg::EXT_RAM_BASE // see RULE10 RULE17
		&& addr_q <= amap_pkg::EXT_WIN_TOP) else $error("external access outside window");
	a_ext_fetch_narrow: assert property (req_valid && req_ready && req_fetch && !ext_width16 // see RULE14
		&& req_addr >= amap_pkg::EXT_RAM_BASE && req_addr <= amap_pkg::EXT_WIN_TOP
		|=> resp_valid && resp_err) else $error("narrow fetch not refused");
endmodule // addr_map_decoder

/* File: core/amap_pkg.sv */
// map constants, target codes and access sizes for the address decoder
// assumes one flat 32-bit byte address space
package amap_pkg;
	localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
	localparam logic [31:0] CODE_SRAM_BASE = 32'h1fff_8000;
	localparam logic [31:0] SRAM_BLK_TOP = 32'h2000_7fff;
	localparam logic [31:0] BB_ALIAS_BASE = 32'h2200_0000;
	localparam logic [31:0] BB_ALIAS_TOP = 32'h23ff_ffff;
	localparam logic [31:0] SRAM_REGION_TOP = 32'h3fff_ffff;
	localparam logic [31:0] EXT_REGS_BASE = 32'h4000_5400;
	localparam logic [31:0] EXT_REGS_TOP = 32'h4000_54ff;
	localparam logic [31:0] EXT_RAM_BASE = 32'h6000_0000;
	localparam logic [31:0] EXT_WIN_TOP = 32'h60ff_ffff;
	localparam logic [31:0] EXT_PERIPH_BASE = 32'ha000_0000;
	localparam logic [31:0] EXT_PERIPH_TOP = 32'hdfff_ffff;
	localparam logic [31:0] PRIV_BASE = 32'he000_0000;
	localparam logic [31:0] PRIV_TOP = 32'he00f_ffff;
	localparam logic [31:0] SYS_HI_BASE = 32'he010_0000;
	localparam int SRAM_BLK_BYTES = 32768;
	localparam int EXT_ADDR_BITS = 24;
	localparam int EXT_ACCESS_CYCLES = 4;
	localparam int BB_DATA_BIT = 0;
	typedef enum logic [1:0] {BUS_CODE, BUS_SYS, BUS_PRIV} bus_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} acc_size_t;
	typedef enum logic [2:0] {
		TGT_FWD, TGT_SRAM_CODE, TGT_SRAM_SYS, TGT_BITBAND, TGT_EXT, TGT_FAULT
	} target_t;
endpackage

/* File: core/ext_unit_if.sv */
// one external memory unit access between decoder and external interface
// assumes issuer holds valid and data steady until done
`timescale 1ns/10ps
interface ext_unit_if;
	logic valid;
	logic [amap_pkg::EXT_ADDR_BITS-1:0] addr;
	logic write;
	logic [1:0] be;
	logic [15:0] wdata;
	logic wide;
	logic sync;
	logic done;
	logic [15:0] rdata;
	modport issuer(output valid, addr, write, be, wdata, wide, sync, input done, rdata);
	modport target(input valid, addr, write, be, wdata, wide, sync, output done, rdata);
endinterface

/* File: core/sram_bank.sv */
// single-port word sram with byte enables and one-cycle registered read
// assumes en, we and be are settled before the clock edge
`timescale 1ns/10ps
module sram_bank #(
	parameter int WORDS = 8192
) (
	input logic sys_clk,
	input logic en,
	input logic we,
	input logic [3:0] be,
	input logic [$clog2(WORDS)-1:0] addr,
	input logic [31:0] wdata,
	output logic [31:0] rdata
);
	logic [31:0] mem [WORDS];

	always_ff @(posedge sys_clk) begin
		if (en && we) begin
			for (int b = 0; b < 4; b++) begin
				if (be[b]) begin
					mem[addr][8*b +: 8] <= wdata[8*b +: 8];
				end
			end
		end
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end
endmodule // sram_bank

/* File: core/ext_mem_if.sv */
// external memory sequencer: one unit access takes a fixed four-cycle frame
// assumes attached memory width matches the wide setting carried with each unit
`timescale 1ns/10ps
module ext_mem_if (
	input logic sys_clk,
	input logic rst,
	ext_unit_if.target unit,
	output logic [amap_pkg::EXT_ADDR_BITS-1:0] ext_addr,
	output logic [15:0] ext_dq_out,
	input logic [15:0] ext_dq_in,
	output logic ext_dq_oe_n,
	output logic ext_cs_n,
	output logic ext_oe_n,
	output logic ext_we_n,
	output logic [1:0] ext_be_n,
	output logic ext_adv_n,
	output logic ext_sclk
);
	localparam logic [1:0] LAST_PH = 2'(amap_pkg::EXT_ACCESS_CYCLES - 1);

	if (amap_pkg::EXT_ACCESS_CYCLES != 4) begin : g_chk
		$error("phase counter serves four-cycle frames only");
	end

	logic busy_q, busy_d, write_q, write_d, wide_q, wide_d, sync_q, sync_d;
	logic [1:0] ph_q, ph_d, be_n_q, be_n_d;
	logic [amap_pkg::EXT_ADDR_BITS-1:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;

	always_comb begin
		busy_d = busy_q;
		ph_d = ph_q;
		write_d = write_q;
		wide_d = wide_q;
		sync_d = sync_q;
		be_n_d = be_n_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		if (!busy_q && unit.valid) begin
			// fetches and reads go out unchecked: no protection here // see RULE15
			busy_d = 1'b1;
			ph_d = 2'd0;
			addr_d = unit.addr; // see RULE18
			write_d = unit.write;
			wdata_d = unit.wdata;
			be_n_d = ~unit.be;
			wide_d = unit.wide; // see RULE11
			sync_d = unit.sync; // see RULE13
		end else if (busy_q) begin
			ph_d = ph_q + 2'd1;
			if (ph_q == 2'd2 && !write_q) begin
				// narrow memory drives only the low lane // see RULE11
				rdata_d = wide_q ? ext_dq_in : {8'h00, ext_dq_in[7:0]};
			end
			if (ph_q == LAST_PH) begin
				busy_d = 1'b0; // see RULE12
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			ph_q <= 2'd0;
			write_q <= 1'b0;
			wide_q <= 1'b0;
			sync_q <= 1'b0;
			be_n_q <= 2'b11;
			addr_q <= '0;
			wdata_q <= 16'h0000;
			rdata_q <= 16'h0000;
		end else begin
			busy_q <= busy_d;
			ph_q <= ph_d;
			write_q <= write_d;
			wide_q <= wide_d;
			sync_q <= sync_d;
			be_n_q <= be_n_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
		end
	end

	assign unit.done = busy_q && ph_q == LAST_PH;
	assign unit.rdata = rdata_q;
	assign ext_addr = addr_q;
	assign ext_dq_out = wdata_q;
	assign ext_be_n = be_n_q;
	assign ext_cs_n = !busy_q;
	assign ext_adv_n = !(busy_q && ph_q == 2'd0);
	assign ext_oe_n = !(busy_q && !write_q && ph_q != 2'd0);
	assign ext_we_n = !(busy_q && write_q && (ph_q == 2'd1 || ph_q == 2'd2));
	assign ext_dq_oe_n = !(busy_q && write_q);
	// synchronous parts get two rising edges per frame; async parts see none
	assign ext_sclk = sync_q && busy_q && ph_q[0]; // see RULE13

	a_ext_four_cycles: assert property (@(posedge sys_clk) disable iff (rst) // see RULE12
		$fell(ext_cs_n) |-> (!ext_cs_n)[*4] ##1 ext_cs_n)
		else $error("external frame is not four cycles");
	a_ext_addr_pass: assert property (@(posedge sys_clk) disable iff (rst) // see RULE18
		$fell(ext_cs_n) |-> ext_addr == $past(unit.addr))
		else $error("external address differs from unit address");
	a_narrow_upper: assert property (@(posedge sys_clk) disable iff (rst) // see RULE11
		unit.done && !wide_q && !write_q |-> unit.rdata[15:8] == 8'h00)
		else $error("narrow read returned upper lane");
endmodule // ext_mem_if

/* File: test/ext_mem_model.sv */
// byte-wide or half-word-wide external memory answering on the parallel pins
// assumes wide follows the width the decoder was told at the last request
`timescale 1ns/10ps
module ext_mem_model (
	input logic sys_clk,
	input logic [23:0] ext_addr,
	input logic [15:0] ext_dq_out,
	output logic [15:0] ext_dq_in,
	input logic ext_cs_n,
	input logic ext_oe_n,
	input logic ext_we_n,
	input logic [1:0] ext_be_n,
	input logic wide
);
	logic [7:0] mem [0:511];
	logic [15:0] rd;
	logic [15:0] last_q = 16'h0000;
	always_comb begin
		if (wide)
			rd = {mem[{ext_addr[8:1], 1'b1}], mem[{ext_addr[8:1], 1'b0}]};
		else
			rd = {~last_q[15:8], mem[ext_addr[8:0]]};
	end
	// released bus shows the inverse, so a stale sample never matches
	assign ext_dq_in = (!ext_cs_n && !ext_oe_n) ? rd : ~last_q;
	always @(posedge sys_clk) begin
		if (!ext_cs_n && !ext_oe_n)
			last_q <= rd;
		if (!ext_cs_n && !ext_we_n) begin
			if (wide) begin
				if (!ext_be_n[0])
					mem[{ext_addr[8:1], 1'b0}] <= ext_dq_out[7:0];
				if (!ext_be_n[1])
					mem[{ext_addr[8:1], 1'b1}] <= ext_dq_out[15:8];
			end else if (!ext_be_n[0]) begin
				mem[ext_addr[8:0]] <= ext_dq_out[7:0];
			end
		end
	end
endmodule // ext_mem_model

/* File: test/address_map_decoder_with_ext_mem_bench.sv */
// self-checking bench for the address decoder with external memory model
// assumes a forwarding fabric that answers one cycle after each request
`timescale 1ns/10ps
module address_map_decoder_with_ext_mem_bench;
	localparam amap_pkg::acc_size_t W = amap_pkg::SZ_WORD;
	localparam logic [31:0] R_ADDR [6] = '{32'h0000_1000, 32'h4000_0000, 32'hc000_0000,
		32'he000_e000, 32'he010_0000, 32'h4000_5400};
	localparam logic [1:0] R_BUS [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
	logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
	logic fwd_ready = 1'b0, fwd_err = 1'b0, ext_width16 = 1'b1, ext_sync = 1'b1;
	logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, fwd_rdata = 32'h0;
	amap_pkg::acc_size_t req_size = amap_pkg::SZ_WORD;
	logic req_ready, resp_valid, resp_err, fwd_valid, fwd_ext_regs, fwd_write;
	logic [31:0] resp_rdata, fwd_addr, fwd_wdata, rd, seen_wd;
	logic [2:0] seen_wr;
	amap_pkg::bus_t fwd_bus;
	amap_pkg::acc_size_t fwd_size;
	logic [23:0] ext_addr, last_addr;
	logic [15:0] ext_dq_out, ext_dq_in;
	logic [1:0] ext_be_n, seen_bus;
	logic ext_dq_oe_n, ext_cs_n, ext_oe_n, ext_we_n, ext_adv_n, ext_sclk, er, seen_regs;
	logic saw_sclk = 1'b0;
	int run = 0, bad_count = 0, compares = 0;
	addr_map_decoder dut_u (.sys_clk, .rst, .req_valid, .req_ready, .req_addr, .req_size,
		.req_write, .req_fetch, .req_wdata, .resp_valid, .resp_rdata, .resp_err, .fwd_valid,
		.fwd_ready, .fwd_bus, .fwd_ext_regs, .fwd_addr, .fwd_size, .fwd_write, .fwd_wdata,
		.fwd_rdata, .fwd_err, .ext_width16, .ext_sync, .ext_addr, .ext_dq_out, .ext_dq_in,
		.ext_dq_oe_n, .ext_cs_n, .ext_oe_n, .ext_we_n, .ext_be_n, .ext_adv_n, .ext_sclk);
	ext_mem_model mem_u (.sys_clk, .ext_addr, .ext_dq_out, .ext_dq_in, .ext_cs_n, .ext_oe_n,
		.ext_we_n, .ext_be_n, .wide(ext_width16));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic wrap_up();
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one access, request held until taken, answer caught in its single cycle
	task automatic acc(input logic [31:0] a, input amap_pkg::acc_size_t sz, input logic wr,
		input logic fe, input logic [31:0] wd);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_addr <= a;
		req_size <= sz;
		req_write <= wr;
		req_fetch <= fe;
		req_wdata <= wd;
		#1;
		while (req_ready !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
		while (resp_valid !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 300) begin
			bad_count++;
			$display("unexpected at %0t: no answer", $time);
			wrap_up();
		end else begin
			rd = resp_rdata;
			er = resp_err;
			@(posedge sys_clk);
		end
	endtask
	always @(posedge sys_clk) begin
		fwd_ready <= fwd_valid && !fwd_ready;
		fwd_rdata <= ~fwd_addr;
		if (fwd_valid && fwd_ready) begin
			seen_bus <= fwd_bus;
			seen_regs <= fwd_ext_regs;
			seen_wr <= {fwd_size, fwd_write};
			seen_wd <= fwd_wdata;
		end
		if (ext_sclk === 1'b1)
			saw_sclk <= 1'b1;
		if (ext_cs_n === 1'b0) begin
			run <= run + 1;
			if (run == 0) begin
				last_addr <= ext_addr;
				// first phase: address strobe only, lanes driven only on writes
				chk(32'({ext_adv_n, ext_oe_n, ext_dq_oe_n}), {30'h1, !req_write});
			end
		end else if (run != 0) begin
			run <= 0;
			chk(32'(run), 32'd4);
		end
	end
	task automatic t_sram();
		acc(32'h1fff_8000, W, 1'b1, 1'b0, 32'h1111_2222);
		acc(32'h2000_0000, W, 1'b1, 1'b0, 32'h3333_4444);
		acc(32'h1fff_8000, W, 1'b0, 1'b0, 32'h0);
		chk(rd, 32'h1111_2222);
		acc(32'h2000_0000, W, 1'b0, 1'b1, 32'h0);
		chk(rd, 32'h3333_4444);
		chk(32'(er), 32'd0);
	endtask
	task automatic t_alias();
		acc(32'h2200_000c, W, 1'b1, 1'b0, 32'h0000_0001);
		acc(32'h2200_0008, W, 1'b1, 1'b0, 32'hffff_fffe);
		acc(32'h2000_0000, W, 1'b0, 1'b0, 32'h0);
		chk(rd, 32'h3333_4448);
		acc(32'h2200_000c, W, 1'b0, 1'b0, 32'h0);
		chk(rd, 32'h0000_0001);
		acc(32'h2200_0008, W, 1'b0, 1'b0, 32'h0);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_unal();
		acc(32'h2000_0011, W, 1'b1, 1'b0, 32'haabb_ccdd);
		acc(32'h2000_0023, amap_pkg::SZ_HALF, 1'b1, 1'b0, 32'h0000_beef);
		acc(32'h2000_0011, W, 1'b0, 1'b0, 32'h0);
		chk(rd, 32'haabb_ccdd);
		acc(32'h2000_0023, amap_pkg::SZ_HALF, 1'b0, 1'b0, 32'h0);
		chk(rd & 32'h0000_ffff, 32'h0000_beef);
	endtask
	task automatic t_route();
		for (int i = 0; i < 6; i++) begin
			seen_bus <= 2'h3;
			acc(R_ADDR[i], W, 1'b0, i == 0, 32'h0);
			chk(32'(seen_bus), 32'(R_BUS[i]));
			chk(32'(seen_regs), 32'(i == 5));
			chk(rd, ~R_ADDR[i]);
		end
		acc(32'h4000_0010, amap_pkg::SZ_HALF, 1'b1, 1'b0, 32'h0000_1234);
		chk({29'h0, seen_wr}, 32'h0000_0003);
		chk(seen_wd, 32'h0000_1234);
	endtask
	task automatic t_ext();
		acc(32'h6012_3454, W, 1'b1, 1'b0, 32'hcafe_f00d);
		acc(32'h6012_3454, W, 1'b0, 1'b1, 32'h0);
		chk(rd, 32'hcafe_f00d);
		chk(32'(er), 32'd0);
		chk(32'(saw_sclk), 32'd1);
		acc(32'h6012_3455, amap_pkg::SZ_BYTE, 1'b0, 1'b0, 32'h0);
		chk(rd & 32'h0000_00ff, 32'h0000_00f0);
		chk(32'(last_addr), 32'h0012_3455);
		acc(32'h6100_0000, W, 1'b0, 1'b0, 32'h0);
		chk(32'(er), 32'd1);
		ext_width16 <= 1'b0;
		ext_sync <= 1'b0;
		saw_sclk <= 1'b0;
		acc(32'h6000_0021, amap_pkg::SZ_BYTE, 1'b1, 1'b0, 32'h0000_005a);
		acc(32'h6000_0021, amap_pkg::SZ_BYTE, 1'b0, 1'b0, 32'h0);
		chk(rd & 32'h0000_00ff, 32'h0000_005a);
		acc(32'h6000_0020, amap_pkg::SZ_HALF, 1'b0, 1'b1, 32'h0);
		chk(32'(er), 32'd1);
		chk(32'(saw_sclk), 32'd0);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_sram();
		t_alias();
		t_unal();
		t_route();
		t_ext();
		wrap_up();
	end
endmodule // address_map_decoder_with_ext_mem_bench
